/* File: hdl/cer_pkg.sv */
// Constants and types for the command error reporter
package cer_pkg;
   localparam int AW = 4;
   localparam int DW = 32;
   localparam int CODE_W = 4;
   localparam int NDIAG = 3;
   // Register byte offsets
   localparam logic [AW-1:0] OFS_CTRL = 4'h0;
   localparam logic [AW-1:0] OFS_CMD = 4'h4;
   localparam logic [AW-1:0] OFS_FLAGS = 4'h8;
   localparam logic [AW-1:0] OFS_CODE = 4'hC;
   // Field positions
   localparam int CTRL_CALM_BIT = 0;
   localparam int CMD_RST_BIT = 0;
   localparam int FLG_ASTS = 0;
   localparam int FLG_STS = 1;
   localparam int FLG_SPOLL = 2;
   localparam int FLG_FAULT = 3;
   localparam int NFLG = 4;
   localparam int FLAGS_IND_LSB = 4;
   localparam int FLAGS_CALM_BIT = 8;
   // Error codes
   localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;
   localparam logic [CODE_W-1:0] CODE_PARSE = 4'h4;
   localparam logic [CODE_W-1:0] CODE_RANGE = 4'h5;
   localparam logic [CODE_W-1:0] CODE_SOFT = 4'h6;
   localparam logic [CODE_W-1:0] CODE_LIMIT = 4'h7;
   localparam logic [CODE_W-1:0] CODE_NOQRY = 4'h8;
   localparam logic [CODE_W-1:0] CODE_OVP = 4'h9;
   localparam logic [CODE_W-1:0] CODE_SUBNR = 4'hA;
   localparam logic [CODE_W-1:0] CODE_CAL = 4'hC;
   // Reset values
   localparam logic RST_WAIT = 1'h1;
   localparam logic RST_CALM = 1'h0;
   localparam logic [NFLG-1:0] RST_FLAGS = 4'h0;
   localparam logic [DW-1:0] RST_RDATA = 32'h0000_0000;

   // Command events from the interpreter, one-cycle pulses; cal_cmd is rejected only outside calibration mode
   typedef struct packed {
      logic parse;
      logic range_err;
      logic soft_limit;
      logic improper_limit;
      logic unasked_read;
      logic ovp_below;
      logic sub_no_resp;
      logic cal_cmd;
   } cer_evt_s;

   // Processor recovery events, one-cycle pulses
   typedef struct packed {
      logic sub_restart;
      logic master_restart;
      logic illegal_op_recover;
   } cer_diag_s;
endpackage : cer_pkg

/* File: hdl/cer_top.sv */
// Error code reporter and diagnostic indicators with Avalon-MM registers
module cer_top
   import cer_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // Avalon-MM slave
   input wire logic [AW-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [DW-1:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [DW-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Interpreter and processor recovery events
   input wire cer_evt_s cmd_evt_i,
   input wire cer_diag_s diag_evt_i,
   // Status
   output logic [NFLG-1:0] err_flags_o,
   output logic [CODE_W-1:0] err_code_o,
   output logic calibration_mode_o,
   output logic cal_accept_o,
   output logic [NDIAG-1:0] processor_recovery_indicator_o
);

   logic wait_r;
   logic wait_nxt;
   logic [DW-1:0] rdata_r;
   logic cal_mode_r;
   logic cal_mode_nxt;
   logic [CODE_W-1:0] code_r;
   logic [CODE_W-1:0] code_nxt;
   logic [NFLG-1:0] flags_r;
   logic [NFLG-1:0] flags_nxt;
   logic fresh_r;
   logic fresh_nxt;
   logic cal_acc_r;
   logic [NDIAG-1:0] ind_r;

   // Bus decode
   wire req = avs_read_i | avs_write_i;
   wire accept = req & wait_r;
   wire done = req & ~wait_r;
   wire sel_ctrl = avs_address_i == OFS_CTRL;
   wire sel_cmd = avs_address_i == OFS_CMD;
   wire sel_flags = avs_address_i == OFS_FLAGS;
   wire sel_code = avs_address_i == OFS_CODE;
   wire wr_lo = done & avs_write_i & avs_byteenable_i[0];
   wire wr_ctrl = wr_lo & sel_ctrl;
   wire reset_cmd = wr_lo & sel_cmd & avs_writedata_i[CMD_RST_BIT];
   wire rd_code = done & avs_read_i & sel_code;

   // Error classification, lowest code wins
   wire cal_refused = cmd_evt_i.cal_cmd & ~cal_mode_r;
   wire [CODE_W-1:0] c_cal = cal_refused ? CODE_CAL : CODE_NONE;
   wire [CODE_W-1:0] c_sub = cmd_evt_i.sub_no_resp ? CODE_SUBNR : c_cal;
   wire [CODE_W-1:0] c_ovp = cmd_evt_i.ovp_below ? CODE_OVP : c_sub;
   wire [CODE_W-1:0] c_nq = cmd_evt_i.unasked_read ? CODE_NOQRY : c_ovp;
   wire [CODE_W-1:0] c_lim = cmd_evt_i.improper_limit ? CODE_LIMIT : c_nq;
   wire [CODE_W-1:0] c_soft = cmd_evt_i.soft_limit ? CODE_SOFT : c_lim;
   wire [CODE_W-1:0] c_rng = cmd_evt_i.range_err ? CODE_RANGE : c_soft;
   wire [CODE_W-1:0] new_code = cmd_evt_i.parse ? CODE_PARSE : c_rng;
   wire err_ev = new_code != CODE_NONE;

   // The clear on a completing read is skipped if an error came after the code was captured or arrives in the same cycle
   wire clr_err = rd_code & ~fresh_r & ~err_ev;

   // Read data mux
   wire [DW-1:0] rd_ctrl = {{(DW-1){1'b0}}, cal_mode_r};
   wire [DW-1:0] rd_flags = {{(DW-FLAGS_CALM_BIT-1){1'b0}}, cal_mode_r,
      {(FLAGS_CALM_BIT-FLAGS_IND_LSB-NDIAG){1'b0}}, ind_r, flags_r};
   wire [DW-1:0] rd_code_w = {{(DW-CODE_W){1'b0}}, code_r};
   wire [DW-1:0] rd_mux = sel_ctrl ? rd_ctrl :
      sel_flags ? rd_flags :
      sel_code ? rd_code_w : RST_RDATA;

   // Next-state terms
   assign wait_nxt = ~accept;
   assign cal_mode_nxt = wr_ctrl ? avs_writedata_i[CTRL_CALM_BIT] : cal_mode_r;
   assign code_nxt = err_ev ? new_code : (clr_err ? CODE_NONE : code_r);
   assign flags_nxt = err_ev ? {NFLG{1'b1}} : (clr_err ? RST_FLAGS : flags_r);
   assign fresh_nxt = err_ev | (fresh_r & ~accept);

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_r <= RST_WAIT;
         rdata_r <= RST_RDATA;
         cal_mode_r <= RST_CALM;
         code_r <= CODE_NONE;
         flags_r <= RST_FLAGS;
         fresh_r <= 1'b0;
         cal_acc_r <= 1'b0;
      end else begin
         wait_r <= wait_nxt;
         if (accept) begin
            rdata_r <= avs_read_i ? rd_mux : RST_RDATA;
         end
         cal_mode_r <= cal_mode_nxt;
         code_r <= code_nxt;
         flags_r <= flags_nxt;
         fresh_r <= fresh_nxt;
         cal_acc_r <= cmd_evt_i.cal_cmd & cal_mode_r;
      end
   end

   // Latched diagnostic indicators, a new event wins over the reset command
   genvar gi;
   generate
      for (gi = 0; gi < NDIAG; gi++) begin : g_ind
         always_ff @(posedge core_clk_i or posedge rst_i) begin
            if (rst_i) begin
               ind_r[gi] <= 1'b0;
            end else begin
               ind_r[gi] <= diag_evt_i[gi] | (ind_r[gi] & ~reset_cmd);
            end
         end
      end
   endgenerate

   assign avs_waitrequest_o = wait_r;
   assign avs_readdata_o = rdata_r;
   assign err_flags_o = flags_r;
   assign err_code_o = code_r;
   assign calibration_mode_o = cal_mode_r;
   assign cal_accept_o = cal_acc_r;
   assign processor_recovery_indicator_o = ind_r;

   // Checks
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   bus_answer_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest not released one cycle after request");

   code_report_a: assert property (
      avs_read_i && sel_code && !avs_waitrequest_o |->
      avs_readdata_o[CODE_W-1:0] == $past(code_r))
      else $error("error query data differs from stored code");

   flag_clear_a: assert property (
      avs_read_i && sel_code && !avs_waitrequest_o && !err_ev && !$past(err_ev)
      |=> err_flags_o == RST_FLAGS)
      else $error("error flags not cleared by error query");

   spoll_clear_a: assert property (
      avs_read_i && sel_code && !avs_waitrequest_o && !err_ev && !$past(err_ev)
      |=> !err_flags_o[FLG_SPOLL] && !err_flags_o[FLG_ASTS])
      else $error("serial poll error bit not cleared by query");

   parse_code_a: assert property (
      cmd_evt_i.parse |=> err_code_o == CODE_PARSE && err_flags_o[FLG_STS])
      else $error("parse failure not reported as code 4");

   range_code_a: assert property (
      cmd_evt_i.range_err && !cmd_evt_i.parse |=> err_code_o == CODE_RANGE)
      else $error("range error not reported as code 5");

   soft_code_a: assert property (
      cmd_evt_i.soft_limit && !cmd_evt_i.parse && !cmd_evt_i.range_err
      |=> err_code_o == CODE_SOFT)
      else $error("soft limit excess not reported as code 6");

   sub_code_a: assert property (
      cmd_evt_i == cer_evt_s'(8'h02) |=> err_code_o == CODE_SUBNR)
      else $error("silent subordinate not reported as code 10");

   cal_refuse_a: assert property (
      cmd_evt_i == cer_evt_s'(8'h01) && !calibration_mode_o
      |=> err_code_o == CODE_CAL && !cal_accept_o)
      else $error("calibration outside calibration mode not refused");

   code_revert_a: assert property (
      rd_code && !fresh_r && !err_ev |=> err_code_o == CODE_NONE [*2] or err_ev)
      else $error("stored code not reverted to 0 after query");

   green_ind_a: assert property (
      diag_evt_i.illegal_op_recover |=> processor_recovery_indicator_o[0])
      else $error("green indicator not lit on opcode recovery");

   red_ind_a: assert property (
      diag_evt_i.master_restart |=> processor_recovery_indicator_o[1] [*1]
      ##1 processor_recovery_indicator_o[1] || $past(reset_cmd))
      else $error("master restart indicator not latched");

   red2_ind_a: assert property (
      diag_evt_i.sub_restart |=> processor_recovery_indicator_o[2])
      else $error("subordinate restart indicator not lit");

   ind_reset_a: assert property (
      reset_cmd && diag_evt_i == cer_diag_s'(3'h0)
      |=> processor_recovery_indicator_o == '0)
      else $error("reset command did not clear indicators");

   limit_code_a: assert property (
      cmd_evt_i == cer_evt_s'(8'h10) |=> err_code_o == CODE_LIMIT)
      else $error("improper soft limit not reported as code 7");

   noqry_code_a: assert property (
      cmd_evt_i == cer_evt_s'(8'h08) |=> err_code_o == CODE_NOQRY)
      else $error("unasked read not reported as code 8");

   ovp_code_a: assert property (
      cmd_evt_i == cer_evt_s'(8'h04) |=> err_code_o == CODE_OVP)
      else $error("low trip setting not reported as code 9");

   cal_accept_a: assert property (
      cmd_evt_i.cal_cmd && calibration_mode_o |=> cal_accept_o)
      else $error("calibration command in calibration mode not accepted");

   accept_idle_a: assert property (
      !cmd_evt_i.cal_cmd |=> !cal_accept_o)
      else $error("calibration accept without calibration command");

   flags_set_a: assert property (
      cmd_evt_i[7:1] != '0 || (cmd_evt_i.cal_cmd && !calibration_mode_o)
      |=> err_flags_o == {NFLG{1'b1}})
      else $error("error flags not set by rejected command");

   code_hold_a: assert property (
      cmd_evt_i == '0 && !(avs_read_i && sel_code && !avs_waitrequest_o)
      |=> $stable(err_code_o))
      else $error("stored code changed without event or query");

   flags_hold_a: assert property (
      err_flags_o[FLG_ASTS] && !(avs_read_i && sel_code && !avs_waitrequest_o)
      |=> err_flags_o[FLG_ASTS])
      else $error("error flag dropped without error query");

   code_flags_a: assert property (
      err_code_o != CODE_NONE |-> err_flags_o == {NFLG{1'b1}})
      else $error("stored code without error flags");

   fault_code_a: assert property (
      err_flags_o[FLG_FAULT] |-> err_code_o != CODE_NONE)
      else $error("fault error flag without stored code");

   green_hold_a: assert property (
      processor_recovery_indicator_o[0] && !(avs_write_i && sel_cmd && !avs_waitrequest_o)
      |=> processor_recovery_indicator_o[0])
      else $error("green indicator dropped without reset command");

   red_hold_a: assert property (
      processor_recovery_indicator_o[1] && !(avs_write_i && sel_cmd && !avs_waitrequest_o)
      |=> processor_recovery_indicator_o[1])
      else $error("first red indicator dropped without reset command");

   red2_hold_a: assert property (
      processor_recovery_indicator_o[2] && !(avs_write_i && sel_cmd && !avs_waitrequest_o)
      |=> processor_recovery_indicator_o[2])
      else $error("second red indicator dropped without reset command");

   ind_quiet_a: assert property (
      diag_evt_i == '0 && processor_recovery_indicator_o == '0
      |=> processor_recovery_indicator_o == '0)
      else $error("indicator lit without event");

   bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");

   bus_idle_a: assert property (!req |=> avs_waitrequest_o)
      else $error("waitrequest low without request");

   cal_write_a: assert property (
      avs_write_i && sel_ctrl && !avs_waitrequest_o && avs_byteenable_i[0]
      |=> calibration_mode_o == $past(avs_writedata_i[CTRL_CALM_BIT]))
      else $error("calibration mode not taken from control write");

   cal_stable_a: assert property (
      !(avs_write_i && sel_ctrl && !avs_waitrequest_o) |=> $stable(calibration_mode_o))
      else $error("calibration mode changed without control write");

   unmapped_read_a: assert property (
      avs_read_i && !avs_waitrequest_o && !sel_ctrl && !sel_flags && !sel_code
      |-> avs_readdata_o == RST_RDATA)
      else $error("unmapped read returned nonzero data");

   cmd_read_a: assert property (
      avs_read_i && sel_cmd && !avs_waitrequest_o |-> avs_readdata_o == RST_RDATA)
      else $error("command register read returned nonzero data");

   ctrl_read_a: assert property (
      avs_read_i && sel_ctrl && !avs_waitrequest_o
      |-> avs_readdata_o[CTRL_CALM_BIT] == $past(calibration_mode_o))
      else $error("control read differs from calibration mode");

   rdata_hold_a: assert property (
      !(req && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed without accepted request");

   flags_read_a: assert property (
      avs_read_i && sel_flags && !avs_waitrequest_o
      |-> avs_readdata_o[NFLG-1:0] == $past(err_flags_o) &&
      avs_readdata_o[FLAGS_IND_LSB+NDIAG-1:FLAGS_IND_LSB] == $past(ind_r))
      else $error("flags read differs from error flags or indicators");

endmodule // cer_top

/* File: verification/cer_ctrl_model.sv */
// Event source standing in for the command interpreter and processor recovery logic
module cer_ctrl_model
   import cer_pkg::*;
(
   // Clock
   input wire logic core_clk_i,
   // Events
   output cer_evt_s cmd_evt_o,
   output cer_diag_s diag_evt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_evt_o = '0;
      diag_evt_o = '0;
   end
   // One-cycle pulse; cal commands normally follow cal mode on
   task automatic pulse(input logic [7:0] e, input logic [2:0] d);
      @(posedge core_clk_i);
      cmd_evt_o <= e;
      diag_evt_o <= d;
      @(posedge core_clk_i);
      cmd_evt_o <= '0;
      diag_evt_o <= '0;
   endtask
endmodule // cer_ctrl_model

/* File: verification/testbench.sv */
// Register and event tests of the command error reporter
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %0h seen %0h", n, e, a); end end
module testbench
   import cer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [AW-1:0] addr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [DW-1:0] wdata = '0;
   logic [DW-1:0] rdata;
   logic [DW-1:0] q;
   logic wreq;
   cer_evt_s evt;
   cer_diag_s diag;
   logic [NFLG-1:0] flags;
   logic [CODE_W-1:0] code;
   logic calm;
   logic acc;
   logic [NDIAG-1:0] ind;
   int n_mismatch = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [CODE_W-1:0] exp_code [8] = '{CODE_PARSE, CODE_RANGE, CODE_SOFT, CODE_LIMIT,
      CODE_NOQRY, CODE_OVP, CODE_SUBNR, CODE_CAL};
   always #4 clk = ~clk;
   cer_ctrl_model model (.core_clk_i(clk), .cmd_evt_o(evt), .diag_evt_o(diag));
   cer_top uut (.core_clk_i(clk), .rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .cmd_evt_i(evt),
      .diag_evt_i(diag), .err_flags_o(flags), .err_code_o(code),
      .calibration_mode_o(calm), .cal_accept_o(acc),
      .processor_recovery_indicator_o(ind));
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 3000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("waitrequest", RST_WAIT, wreq)
      `CHK("flags", RST_FLAGS, flags)
      `CHK("code", CODE_NONE, code)
      `CHK("indicators", 3'h0, ind)
      `CHK("cal mode", RST_CALM, calm)
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         model.pulse(8'h80 >> i, 3'h0);
         @(negedge clk);
         `CHK("code", exp_code[i], code)
         `CHK("flags", 4'hF, flags)
         `CHK("cal accept", 1'b0, acc)
         bus(1'b0, OFS_CODE, '0);
         `CHK("read code", {28'h0, exp_code[i]}, q)
         @(negedge clk);
         `CHK("flags cleared", 4'h0, flags)
         `CHK("code cleared", CODE_NONE, code)
      end
      $display("test codes done");
      model.pulse(8'h81, 3'h0);
      @(negedge clk);
      `CHK("lowest code", CODE_PARSE, code)
      bus(1'b0, OFS_CODE, '0);
      `CHK("read lowest", {28'h0, CODE_PARSE}, q)
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      @(negedge clk);
      `CHK("cal mode", 1'b1, calm)
      bus(1'b0, OFS_CTRL, '0);
      `CHK("ctrl reg", 32'h0000_0001, q)
      model.pulse(8'h01, 3'h0);
      @(negedge clk);
      `CHK("cal accept", 1'b1, acc)
      `CHK("code", CODE_NONE, code)
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
      $display("test calibration done");
      for (int i = 0; i < 3; i++) begin
         model.pulse(8'h00, 3'h1 << i);
         @(negedge clk);
         `CHK("indicators", 3'((4'h2 << i) - 4'h1), ind)
      end
      bus(1'b0, OFS_FLAGS, '0);
      `CHK("flags reg", 32'h0000_0070, q)
      bus(1'b1, OFS_CMD, 32'h0000_0001);
      @(negedge clk);
      `CHK("indicators off", 3'h0, ind)
      bus(1'b0, 4'h2, '0);
      `CHK("unmapped read", 32'h0000_0000, q)
      $display("test indicators done");
      end_of_test();
   end
endmodule // testbench
